// >>> src/tlfc_pkg.sv
// Constants for the tri-level frequency-control host link.
// Assumes a 250 MHz system clock; all timing is counted in its cycles.
package tlfc_pkg;
  localparam int CLK_MHZ = 250;
  // Symbol phase times in ns (high/low and middle least 500 ns each)
  localparam int T_LOGIC_NS = 500;
  localparam int T_MIDDLE_NS = 500;
  localparam int LOGIC_CYC = (T_LOGIC_NS * CLK_MHZ + 999) / 1000;
  localparam int MIDDLE_CYC = (T_MIDDLE_NS * CLK_MHZ + 999) / 1000;
  // Frame timing in us
  localparam int T_FRAME_US = 40;
  localparam int T_GAP_US = 2;
  localparam int FRAME_CYC = T_FRAME_US * CLK_MHZ;
  localparam int GAP_CYC = T_GAP_US * CLK_MHZ;
  // Update rate limit of two-frame mode: 12.5 K per second -> 80 us
  localparam int T_UPDATE_US = 80;
  localparam int UPDATE_CYC = T_UPDATE_US * CLK_MHZ;
  // Frame layout
  localparam int FRAME_BITS = 40;
  localparam logic [7:0] HDR_HI = 8'hfa;
  localparam logic [3:0] HDR_LO = 4'ha;
  localparam logic [7:0] ADDR_UPPER = 8'h06;
  localparam logic [7:0] ADDR_LOW = 8'h07;
  // Software register offsets of the controller
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_VALUE = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam int CTRL_MODE2 = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_ADDR_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0;
endpackage

// >>> src/tlfc_host.sv
// Host controller that drives the single tri-level control pin of a pulled oscillator.
// Assumes an external tri-state pin: out_en low lets a resistor divider make the middle level.
//
// Strobed register access was chosen for this implementation.
module tlfc_host #(
  parameter int FRAME_CYCLES = tlfc_pkg::FRAME_CYC,
  parameter int UPDATE_CYCLES = tlfc_pkg::UPDATE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Tri-level control pin drive
  output logic control_pin_o,
  output logic control_pin_oe
);
  typedef enum logic [2:0] {
    TLFC_IDLE = 3'b000,
    TLFC_DRIVE = 3'b001,
    TLFC_MID = 3'b011,
    TLFC_PAD = 3'b010,
    TLFC_GAP = 3'b110
  } tlfc_state_e;

  // The phase counter also times the 500-cycle gap, which fits in its ten bits
  localparam int PH_W = 10;
  // Frame and rate counters hold the 20000-cycle update window
  localparam int FR_W = 16;

  // Register map of the software port, one 32-bit word per index
  //   0 control: bit 0 two-frame mode, bit 1 go, bits 7:4 device address nibble
  //     A read shows go while it is still pending
  //   1 value: bits 22:0 signed offset, bits 15:0 only in single-frame mode
  //     Writes are dropped while a frame is in flight or go is pending,
  //     so the words on the pin always come from one consistent value
  //   2 status: bit 0 busy, bit 1 rate window open, bits 31:16 frame count
  //   Any other index reads as zero; read data stand one cycle only

  // Pin timing per bit, in clock cycles
  //   Drive phase: enable high for the logic phase count, data shows the bit
  //   Middle phase: enable low for the middle phase count, divider settles
  //   A frame of forty bits is padded up to the frame length, then the pin
  //   stays released for the gap; a two-frame update sends its second frame
  //   right after that gap.
  //   Data and enable both come from flip-flops fed by one state, so an
  //   external buffer never sees enable lead the data by a gate delay

  tlfc_state_e state_q;
  logic mode2_q;
  logic [3:0] dev_addr_q;
  logic [22:0] value_q;
  logic go_q;
  logic [39:0] shreg_q;
  logic [5:0] bit_cnt_q;
  logic [PH_W-1:0] ph_cnt_q;
  logic [FR_W-1:0] fr_cnt_q;
  logic [FR_W-1:0] rate_cnt_q;
  logic second_q;
  logic [31:0] frames_q;
  logic start;
  logic [39:0] frame_upper;
  logic [39:0] frame_low;
  logic [15:0] upper_word;
  logic [15:0] low_word;
  logic last_bit;

  // Split the offset into upper word and low seven bits
  always_comb begin
    if (mode2_q) begin
      upper_word = value_q[22:7];
      low_word = {9'h000, value_q[6:0]};
    end else begin
      upper_word = value_q[15:0];
      low_word = 16'h0000;
    end
    frame_upper = {tlfc_pkg::HDR_HI, dev_addr_q, tlfc_pkg::HDR_LO,
                   tlfc_pkg::ADDR_UPPER, upper_word};
    frame_low = {tlfc_pkg::HDR_HI, dev_addr_q, tlfc_pkg::HDR_LO,
                 tlfc_pkg::ADDR_LOW, low_word};
  end

  // Update may start only when idle and the rate window has elapsed
  assign start = go_q && state_q == TLFC_IDLE && rate_cnt_q == '0;
  assign last_bit = bit_cnt_q == 6'(tlfc_pkg::FRAME_BITS - 1);

  // Software control writes; GO stays pending until the link takes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode2_q <= 1'b0;
      dev_addr_q <= 4'h0;
      value_q <= 23'h000000;
      go_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == tlfc_pkg::OFS_CTRL) begin
        mode2_q <= reg_wdata[tlfc_pkg::CTRL_MODE2];
        dev_addr_q <= reg_wdata[tlfc_pkg::CTRL_ADDR_LSB +: 4];
      end
      if (reg_wr && reg_addr == tlfc_pkg::OFS_VALUE && state_q == TLFC_IDLE && !go_q) begin
        value_q <= reg_wdata[22:0];
      end
      if (start) begin
        go_q <= 1'b0;
      end else if (reg_wr && reg_addr == tlfc_pkg::OFS_CTRL && reg_wdata[tlfc_pkg::CTRL_GO]) begin
        go_q <= 1'b1;
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        tlfc_pkg::OFS_CTRL: reg_rdata <= {24'h0, dev_addr_q, 2'b00, go_q, mode2_q};
        tlfc_pkg::OFS_VALUE: reg_rdata <= {9'h0, value_q};
        tlfc_pkg::OFS_STATUS: reg_rdata <= {frames_q[15:0], 14'h0,
                                            rate_cnt_q != '0, state_q != TLFC_IDLE};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Symbol sequencer: drive phase, middle phase, frame padding, gap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= TLFC_IDLE;
      shreg_q <= 40'h0;
      bit_cnt_q <= 6'h0;
      ph_cnt_q <= '0;
      second_q <= 1'b0;
    end else begin
      unique case (state_q)
        TLFC_IDLE: begin
          if (start) begin
            shreg_q <= mode2_q ? frame_low : frame_upper;
            second_q <= mode2_q;
            bit_cnt_q <= 6'h0;
            ph_cnt_q <= '0;
            state_q <= TLFC_DRIVE;
          end
        end
        TLFC_DRIVE: begin
          ph_cnt_q <= ph_cnt_q + 1'b1;
          if (ph_cnt_q == PH_W'(tlfc_pkg::LOGIC_CYC - 1)) begin
            ph_cnt_q <= '0;
            state_q <= TLFC_MID;
          end
        end
        TLFC_MID: begin
          ph_cnt_q <= ph_cnt_q + 1'b1;
          if (ph_cnt_q == PH_W'(tlfc_pkg::MIDDLE_CYC - 1)) begin
            ph_cnt_q <= '0;
            shreg_q <= {shreg_q[38:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            state_q <= last_bit ? TLFC_PAD : TLFC_DRIVE;
          end
        end
        TLFC_PAD: begin
          if (fr_cnt_q >= FR_W'(FRAME_CYCLES - 1)) begin
            ph_cnt_q <= '0;
            state_q <= TLFC_GAP;
          end
        end
        TLFC_GAP: begin
          ph_cnt_q <= ph_cnt_q + 1'b1;
          if (ph_cnt_q == PH_W'(tlfc_pkg::GAP_CYC - 1)) begin
            ph_cnt_q <= '0;
            if (second_q) begin
              second_q <= 1'b0;
              shreg_q <= frame_upper;
              bit_cnt_q <= 6'h0;
              state_q <= TLFC_DRIVE;
            end else begin
              state_q <= TLFC_IDLE;
            end
          end
        end
        default: state_q <= TLFC_IDLE;
      endcase
    end
  end

  // Frame length counter, restarted at each frame's first symbol
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fr_cnt_q <= '0;
    end else if (state_q == TLFC_IDLE || state_q == TLFC_GAP) begin
      fr_cnt_q <= '0;
    end else if (fr_cnt_q != '1) begin
      fr_cnt_q <= fr_cnt_q + 1'b1;
    end
  end

  // Update-rate window started with each update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate_cnt_q <= '0;
      frames_q <= 32'h0;
    end else begin
      if (start) begin
        rate_cnt_q <= FR_W'(UPDATE_CYCLES - 1);
      end else if (rate_cnt_q != '0) begin
        rate_cnt_q <= rate_cnt_q - 1'b1;
      end
      if (state_q == TLFC_PAD && fr_cnt_q >= FR_W'(FRAME_CYCLES - 1)) begin
        frames_q <= frames_q + 32'h1;
      end
    end
  end

  // Pin drive; data and enable come from one state, so they change together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      control_pin_o <= 1'b0;
      control_pin_oe <= 1'b0;
    end else begin
      control_pin_o <= shreg_q[39];
      control_pin_oe <= state_q == TLFC_DRIVE;
    end
  end

  // Assertions on the pin timing and the frame sequence

  // A released middle phase lasts at least eight cycles before the next drive
  chk_mid_after_bit: assert property (@(posedge clk) disable iff (!resetn)
    $fell(control_pin_oe) |-> !control_pin_oe [*8])
    else $error("middle phase shorter than expected");

  // A driven phase lasts at least eight cycles
  chk_drive_len: assert property (@(posedge clk) disable iff (!resetn)
    $rose(control_pin_oe) |-> control_pin_oe [*8])
    else $error("drive phase too short");

  // Data may not move while the pin is driven, or the buffer could glitch
  chk_data_steady: assert property (@(posedge clk) disable iff (!resetn)
    control_pin_oe && $past(control_pin_oe) |-> $stable(control_pin_o))
    else $error("pin data changed during drive phase");

  // Taking go clears it and opens the rate window
  chk_go_taken: assert property (@(posedge clk) disable iff (!resetn)
    start |=> !go_q && rate_cnt_q != '0)
    else $error("start did not arm rate window");

  // No new update while the rate window is open
  chk_rate_block: assert property (@(posedge clk) disable iff (!resetn)
    rate_cnt_q != '0 |-> !start)
    else $error("update started inside rate window");

  // Two-frame updates begin with the low-bits register
  chk_low_first: assert property (@(posedge clk) disable iff (!resetn)
    start && mode2_q |=> shreg_q[23:16] == tlfc_pkg::ADDR_LOW)
    else $error("two-frame update did not begin with low frame");

  // The low-bits word carries only seven offset bits, the rest zero
  chk_low_pad: assert property (@(posedge clk) disable iff (!resetn)
    start && mode2_q |=> shreg_q[15:7] == 9'h000)
    else $error("low word carries bits above bit six");

  // A single-frame update goes straight to the upper word
  chk_upper_addr: assert property (@(posedge clk) disable iff (!resetn)
    start && !mode2_q |=> shreg_q[23:16] == tlfc_pkg::ADDR_UPPER)
    else $error("single frame not addressed to upper word");

  // The second frame of a pair is the upper word
  chk_second_upper: assert property (@(posedge clk) disable iff (!resetn)
    state_q == TLFC_GAP && second_q && ph_cnt_q == PH_W'(tlfc_pkg::GAP_CYC - 1)
    |=> shreg_q[23:16] == tlfc_pkg::ADDR_UPPER)
    else $error("second frame not addressed to upper word");

  // The pin stays released through the gap
  chk_gap_idle: assert property (@(posedge clk) disable iff (!resetn)
    state_q == TLFC_GAP |-> ##1 !control_pin_oe)
    else $error("pin driven during gap");

  // The gap runs its full count before anything else happens
  chk_gap_len: assert property (@(posedge clk) disable iff (!resetn)
    $past(state_q) == TLFC_GAP && state_q != TLFC_GAP
    |-> $past(ph_cnt_q) == PH_W'(tlfc_pkg::GAP_CYC - 1))
    else $error("gap between frames cut short");

  // Padding starts exactly forty symbol times after the first bit
  chk_pad_len: assert property (@(posedge clk) disable iff (!resetn)
    state_q == TLFC_PAD && $past(state_q) != TLFC_PAD |->
      fr_cnt_q == FR_W'(tlfc_pkg::FRAME_BITS * (tlfc_pkg::LOGIC_CYC + tlfc_pkg::MIDDLE_CYC)))
    else $error("frame symbol time wrong before padding");

  // Every frame holds forty bits
  chk_frame_bits: assert property (@(posedge clk) disable iff (!resetn)
    state_q == TLFC_PAD && $past(state_q) != TLFC_PAD |-> bit_cnt_q == 6'(tlfc_pkg::FRAME_BITS))
    else $error("frame did not hold forty bits");

  // An idle link leaves the pin at the middle level
  chk_idle_mid: assert property (@(posedge clk) disable iff (!resetn)
    state_q == TLFC_IDLE && $past(state_q) == TLFC_IDLE |-> !control_pin_oe)
    else $error("pin driven while idle");

  // The offset cannot change under a frame in flight
  chk_value_lock: assert property (@(posedge clk) disable iff (!resetn)
    state_q != TLFC_IDLE && $past(state_q) != TLFC_IDLE |-> $stable(value_q))
    else $error("offset changed during update");

  // Read data are zero except in the cycle after a read strobe
  chk_rdata_zero: assert property (@(posedge clk) disable iff (!resetn)
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");

  // Main scenarios
  cov_single: cover property (@(posedge clk) disable iff (!resetn) start && !mode2_q);
  cov_double: cover property (@(posedge clk) disable iff (!resetn) start && mode2_q);
  cov_second: cover property (@(posedge clk) disable iff (!resetn)
    state_q == TLFC_GAP && second_q ##1 state_q == TLFC_DRIVE);
  cov_other_addr: cover property (@(posedge clk) disable iff (!resetn)
    start && dev_addr_q != 4'h0);
endmodule

// >>> sim/tlfc_dev_model.sv
// Behavioural oscillator model that decodes the tri-level control pin.
// Assumes oe low means the divider holds the pin at the middle level.
module tlfc_dev_model #(
  parameter logic [3:0] DEV_ADDR = 4'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pin as seen by the oscillator
  input wire logic control_pin_o,
  input wire logic control_pin_oe,
  // Observed state
  output logic [15:0] dev_low,
  output logic [22:0] applied,
  output int upd_cnt,
  output int frm_cnt,
  output int min_gap,
  output int short_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] sh;
  int n;
  int mid;
  int drv;
  logic was_oe;
  logic was_o;
  // Symbol decoder; a bit is taken when the driven phase returns to middle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_low = 16'h0;
      applied = 23'h0;
      {upd_cnt, frm_cnt, short_cnt, n, mid, drv} = '0;
      // The pin has idled long before the first frame
      mid = 100000;
      min_gap = 1000000;
      {was_oe, was_o} = 2'h0;
    end else begin
      if (control_pin_oe) begin
        if (!was_oe && mid < tlfc_pkg::MIDDLE_CYC) short_cnt++;
        else if (!was_oe && mid > 200 && mid < min_gap) min_gap = mid;
        drv++;
        mid = 0;
      end else begin
        if (was_oe) begin
          if (drv < tlfc_pkg::LOGIC_CYC) short_cnt++;
          sh = {sh[38:0], was_o};
          n++;
        end
        drv = 0;
        mid++;
        // A long middle level cuts a partial frame
        if (mid == 300) n = 0;
      end
      if (n == 40) begin
        n = 0;
        // Only a matching header is accepted
        if (sh[39:24] == {tlfc_pkg::HDR_HI, DEV_ADDR, tlfc_pkg::HDR_LO}) begin
          frm_cnt++;
          if (sh[23:16] == tlfc_pkg::ADDR_LOW) dev_low = sh[15:0];
          if (sh[23:16] == tlfc_pkg::ADDR_UPPER) begin
            // Applied at once, well inside the allowed update delay
            applied = {sh[15:0], dev_low[6:0]};
            upd_cnt++;
          end
        end
      end
      was_oe = control_pin_oe;
      was_o = control_pin_o;
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the tri-level host controller.
// Assumes the device model decodes the pin; register port driven here.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic control_pin_o;
  logic control_pin_oe;
  logic [15:0] dev_low;
  logic [22:0] applied;
  int upd_cnt, frm_cnt, min_gap, short_cnt;
  int err_count = 0;
  int checked = 0;
  int exp_upd = 0;
  int exp_frm = 0;
  logic [15:0] exp_lo = 16'h0;
  logic [22:0] exp_app = 23'h0;
  logic [31:0] d;
  // 250 MHz clock
  always #2 clk = ~clk;
  // Short rate window keeps the run brief
  tlfc_host #(.FRAME_CYCLES(10000), .UPDATE_CYCLES(16)) tlfc_host_i (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .control_pin_o(control_pin_o), .control_pin_oe(control_pin_oe));
  tlfc_dev_model tlfc_dev_model_i (
    .clk(clk), .resetn(resetn), .control_pin_o(control_pin_o),
    .control_pin_oe(control_pin_oe), .dev_low(dev_low), .applied(applied),
    .upd_cnt(upd_cnt), .frm_cnt(frm_cnt), .min_gap(min_gap), .short_cnt(short_cnt));
  task automatic conclude;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is valid only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // One update; a second VALUE write while busy must be ignored
  task automatic run(input bit m2, input logic [3:0] na, input logic [22:0] v);
    int i;
    wr(tlfc_pkg::OFS_VALUE, {9'h0, v});
    wr(tlfc_pkg::OFS_CTRL, {24'h0, na, 2'h0, 1'b1, m2});
    repeat (8) @(posedge clk);
    wr(tlfc_pkg::OFS_VALUE, $urandom);
    for (i = 0; i < 30000; i++) begin
      rd(tlfc_pkg::OFS_STATUS);
      if (d[0] === 1'b0) break;
    end
    if (i == 30000) begin
      err_count++;
      conclude();
    end
    // Reference: wrong nibble leaves the device untouched
    if (na == 4'h0) begin
      if (m2) exp_lo = {9'h0, v[6:0]};
      exp_app = m2 ? v : {v[15:0], exp_lo[6:0]};
      exp_upd++;
      exp_frm += m2 ? 2 : 1;
    end
    chk("applied", {9'h0, exp_app}, {9'h0, applied});
    chk("dev_low", {16'h0, exp_lo}, {16'h0, dev_low});
    chk("upd_cnt", exp_upd, upd_cnt);
    chk("frm_cnt", exp_frm, frm_cnt);
  endtask
  initial begin
    int k;
    void'($urandom(92));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(tlfc_pkg::OFS_CTRL);
    chk("ctrl", tlfc_pkg::CTRL_RESET, d);
    rd(tlfc_pkg::OFS_STATUS);
    chk("status", 32'h0, d);
    rd(4'hf);
    chk("unmapped", 32'h0, d);
    chk("applied0", 32'h0, {9'h0, applied});
    // Modes alternate; the last two-frame value is the most negative
    for (k = 0; k < 4; k++) run(k[0], 4'h0, (k == 3) ? 23'h400000 : 23'($urandom));
    run(1'b0, 4'h5, 23'($urandom));
    chk("gap_ok", 32'h1, {31'h0, min_gap >= tlfc_pkg::GAP_CYC});
    chk("short", 32'h0, short_cnt);
    conclude();
  end
endmodule
